// *** key_auth_pkg.sv ***
// Purpose: shared constants for the debug and test-entry key input banks
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package key_auth_pkg;
  localparam int unsigned KEY_WORDS    = 8;
  localparam int unsigned KEY_BITS     = 256;
  localparam int unsigned ADDR_W       = 12;

  localparam logic [11:0] DEBUG_BASE   = 12'h000;
  localparam logic [11:0] TEST_BASE    = 12'h020;
  localparam logic [11:0] STATUS_ADDR  = 12'h040;
  localparam logic [11:0] INT_STAT     = 12'h044;
  localparam logic [11:0] INT_CLEAR    = 12'h048;
  localparam logic [11:0] INT_ENABLE   = 12'h04c;

  // authentication status bit positions
  localparam int unsigned DEBUG_BIT    = 2;
  localparam int unsigned TEST_BIT     = 3;
  // interrupt event bit positions
  localparam int unsigned EV_DEBUG     = 0;
  localparam int unsigned EV_TEST      = 1;
  localparam int unsigned EV_BITS      = 2;

  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
  localparam logic [255:0] ALL_ONES    = {256{1'b1}};
  localparam logic [255:0] ALL_ZERO    = {256{1'b0}};
endpackage : key_auth_pkg

// *** key_bank.sv ***
// Purpose: one eight-word key input bank with its comparator
// Assumes: reference key is stable while it is in use
// Notes:   lock result refreshes on a write to the top word, or every cycle to unlocked while the reference is all ones
`timescale 1ns/1ps
`default_nettype none
module key_bank #(
  parameter int unsigned WORDS = key_auth_pkg::KEY_WORDS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 wr_en,
  input  wire logic [2:0]           wr_idx,
  input  wire logic [31:0]          wr_data,
  input  wire logic [2:0]           rd_idx,
  input  wire logic [WORDS*32-1:0]  ref_key,
  output logic      [31:0]          rd_word,
  output logic                      locked_q,
  output logic                      done_pulse_q
);
  // index ports are three bits wide, so only eight words can be served
  if (WORDS != 8) begin : g_words_check
    $error("key_bank supports eight words only");
  end

  logic [WORDS*32-1:0] key_q;
  logic                top_write;

  assign top_write = wr_en && (wr_idx == 3'(WORDS - 1));

  // word k lands on bits 32k+31:32k
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= '0;
    end else if (wr_en) begin
      key_q[wr_idx*32 +: 32] <= wr_data;
    end
  end

  // compare with the word being written so the top word counts at once
  logic [WORDS*32-1:0] key_next;
  always_comb begin
    key_next = key_q;
    key_next[(WORDS-1)*32 +: 32] = wr_data;
  end

  // reset locked; an all-ones reference needs no key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b1;
    end else if (ref_key == key_auth_pkg::ALL_ONES) begin
      locked_q <= 1'b0;
    end else if (top_write) begin
      locked_q <= (key_next != ref_key);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pulse_q <= 1'b0;
    end else begin
      done_pulse_q <= top_write;
    end
  end

  assign rd_word = key_q[rd_idx*32 +: 32];
endmodule : key_bank
`default_nettype wire

// *** key_auth_top.sv ***
// Purpose: apb slave for debug and test-entry key banks with status, irq
// Assumes: reference keys come from the security setting area read logic
// Notes:   zero wait states; unmapped addresses answer pslverr
`timescale 1ns/1ps
`default_nettype none
module key_auth_top (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [255:0] debug_ref_key,
  input  wire logic [255:0] test_ref_key,
  output logic              pready,
  output logic              pslverr,
  output logic      [31:0]  prdata,
  output logic              debug_locked,
  output logic              test_entry_locked,
  output logic              irq
);
  // reference keys are inputs only: this block never writes them

  logic        setup;
  logic        dbg_hit;
  logic        tst_hit;
  logic        mapped;
  logic [2:0]  idx;
  logic [31:0] dbg_word;
  logic [31:0] tst_word;
  logic        dbg_locked_w;
  logic        tst_locked_w;
  logic        dbg_done;
  logic        tst_done;
  logic [key_auth_pkg::EV_BITS-1:0] int_stat_q;
  logic [key_auth_pkg::EV_BITS-1:0] int_en_q;
  logic [31:0] rdata_d;
  logic [31:0] status_w;

  // answer in the access cycle: registers are sampled at setup
  assign setup   = psel && !penable;
  assign idx     = paddr[4:2];
  assign dbg_hit = paddr[11:5] == key_auth_pkg::DEBUG_BASE[11:5];
  assign tst_hit = paddr[11:5] == key_auth_pkg::TEST_BASE[11:5];
  assign mapped  = dbg_hit || tst_hit ||
                   paddr == key_auth_pkg::STATUS_ADDR ||
                   paddr == key_auth_pkg::INT_STAT ||
                   paddr == key_auth_pkg::INT_CLEAR ||
                   paddr == key_auth_pkg::INT_ENABLE;

  logic access;
  logic wr_dbg;
  logic wr_tst;
  // writes commit at the edge that sees pready; word order is not checked
  assign access = psel && penable && pready;
  assign wr_dbg = access && pwrite && dbg_hit;
  assign wr_tst = access && pwrite && tst_hit;

  key_bank #(.WORDS(key_auth_pkg::KEY_WORDS)) u_debug_bank (
    .pclk         (pclk),
    .presetn      (presetn),
    .wr_en        (wr_dbg),
    .wr_idx       (idx),
    .wr_data      (pwdata),
    .rd_idx       (idx),
    .ref_key      (debug_ref_key),
    .rd_word      (dbg_word),
    .locked_q     (dbg_locked_w),
    .done_pulse_q (dbg_done)
  );

  key_bank #(.WORDS(key_auth_pkg::KEY_WORDS)) u_test_bank (
    .pclk         (pclk),
    .presetn      (presetn),
    .wr_en        (wr_tst),
    .wr_idx       (idx),
    .wr_data      (pwdata),
    .rd_idx       (idx),
    .ref_key      (test_ref_key),
    .rd_word      (tst_word),
    .locked_q     (tst_locked_w),
    .done_pulse_q (tst_done)
  );

  always_comb begin
    status_w = key_auth_pkg::READ_ZERO;
    status_w[key_auth_pkg::DEBUG_BIT] = dbg_locked_w;
    status_w[key_auth_pkg::TEST_BIT]  = tst_locked_w;
  end

  always_comb begin
    rdata_d = key_auth_pkg::READ_ZERO;
    if (dbg_hit) begin
      rdata_d = dbg_word;
    end else if (tst_hit) begin
      rdata_d = tst_word;
    end else if (paddr == key_auth_pkg::STATUS_ADDR) begin
      rdata_d = status_w;
    end else if (paddr == key_auth_pkg::INT_STAT) begin
      rdata_d[key_auth_pkg::EV_BITS-1:0] = int_stat_q;
    end else if (paddr == key_auth_pkg::INT_ENABLE) begin
      rdata_d[key_auth_pkg::EV_BITS-1:0] = int_en_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= key_auth_pkg::READ_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rdata_d : key_auth_pkg::READ_ZERO;
    end
  end

  // sticky comparison-done events; a new event beats a clear
  logic [key_auth_pkg::EV_BITS-1:0] ev;
  logic [key_auth_pkg::EV_BITS-1:0] clr;
  assign ev  = {tst_done, dbg_done};
  assign clr = (access && pwrite && paddr == key_auth_pkg::INT_CLEAR)
               ? pwdata[key_auth_pkg::EV_BITS-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= '0;
    end else if (access && pwrite && paddr == key_auth_pkg::INT_ENABLE) begin
      int_en_q <= pwdata[key_auth_pkg::EV_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq               <= 1'b0;
      debug_locked      <= 1'b1;
      test_entry_locked <= 1'b1;
    end else begin
      irq               <= |(int_stat_q & int_en_q);
      debug_locked      <= dbg_locked_w;
      test_entry_locked <= tst_locked_w;
    end
  end
endmodule : key_auth_top
`default_nettype wire

// *** key_auth_props.sv ***
// Purpose: port assertions for key_auth_top
// Assumes: master holds paddr through the access phase
// Notes:   key words shadowed from apb writes for the compares
`timescale 1ns/1ps
`default_nettype none
module key_auth_props (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic [255:0] debug_ref_key,
  input wire logic [255:0] test_ref_key,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         debug_locked,
  input wire logic         test_entry_locked,
  input wire logic         irq
);
  logic [511:0] kq;
  // a write counts at the access edge that sees pready
  wire          accw = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) kq <= '0;
    else if (accw && paddr < 12'h040) kq[paddr[5:2]*32 +: 32] <= pwdata;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr7d; accw && paddr == 12'h01c; endsequence
  sequence s_wr7t; accw && paddr == 12'h03c; endsequence
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready too long");
  property p_err; pready |-> pslverr == !(paddr < 12'h040 ||
    (paddr <= 12'h04c && paddr[1:0] == 2'b00)); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_dcmp; s_wr7d |=> ##1 debug_locked ==
    (kq[255:0] != debug_ref_key && debug_ref_key != '1); endproperty
  a_dcmp: assert property (p_dcmp) else $error("debug lock");
  property p_tcmp; s_wr7t |=> ##1 test_entry_locked ==
    (kq[511:256] != test_ref_key && test_ref_key != '1); endproperty
  a_tcmp: assert property (p_tcmp) else $error("test lock");
  property p_relock;
    $rose(debug_locked) |-> $past(accw && paddr == 12'h01c, 2); endproperty
  a_relock: assert property (p_relock) else $error("early lock");
  property p_stat; pready && !pwrite && paddr == 12'h040 |->
    prdata == {28'h0, test_entry_locked, debug_locked, 2'b00}; endproperty
  a_stat: assert property (p_stat) else $error("status bit");
  property p_ones; (debug_ref_key == '1) [*3] |-> !debug_locked; endproperty
  a_ones: assert property (p_ones) else $error("ones ref locked");
endmodule : key_auth_props
bind key_auth_top key_auth_props i_key_auth_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .debug_ref_key, .test_ref_key,
  .pready, .pslverr, .debug_locked, .test_entry_locked, .irq);
`default_nettype wire

// *** tb.sv ***
// Purpose: random and corner tests of key_auth_top
// Assumes: zero-wait apb, lock outputs settle within three edges
// Notes:   refs held still except for the all-ones case
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0, ba;
  logic [31:0]  pwdata = '0, rd, prdata;
  logic [255:0] dref, tref, key;
  logic         err, pready, pslverr, irq, dl, tl;
  int           seed = 32'h8531bf40, miscompares = 0, n_tests = 0, cyc, j;
  always #12.5 pclk = ~pclk;
  key_auth_top i_key_auth_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .debug_ref_key(dref), .test_ref_key(tref), .pready,
    .pslverr, .prdata, .debug_locked(dl), .test_entry_locked(tl), .irq);
  function automatic logic [255:0] rkey();
    for (int i = 0; i < 8; i++) rkey[i*32 +: 32] = $random(seed);
  endfunction : rkey
  function automatic logic [31:0] sexp(logic d, logic t);
    return {28'h0, t, d, 2'b00};
  endfunction : sexp
  task chk(string s, logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", s, e, g);
    end
  endtask : chk
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  always @(posedge pclk) if (++cyc == 20000) begin
    miscompares++;
    final_report;
  end
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wkey(logic [11:0] b, logic [255:0] k);
    for (int i = 0; i < 8; i++)
      apb(1'b1, b + 12'(4 * i), k[i*32 +: 32]);
    repeat (3) @(posedge pclk);
  endtask : wkey
  initial begin
    dref = rkey();
    tref = rkey();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h04c, 32'h3);
    apb(1'b0, 12'h040, 0);
    chk("status", rd, sexp(1, 1));
    for (int b = 0; b < 2; b++) for (int k = 0; k < 8; k++) begin
      ba = b ? 12'h020 : 12'h000;
      key = b ? tref : dref;
      j = k * 32 + ($random(seed) & 31);
      key[j] = ~key[j];
      wkey(ba, key);
      chk("locked", b ? tl : dl, 1);
      apb(1'b0, ba + 12'(4 * k), 0);
      chk("word", rd, key[k*32 +: 32]);
      wkey(ba, b ? tref : dref);
      chk("open", b ? tl : dl, 0);
    end
    chk("irq", irq, 1);
    for (int i = 0; i < 7; i++) apb(1'b1, 12'(4 * i), ~dref[i*32 +: 32]);
    repeat (3) @(posedge pclk);
    chk("early", dl, 0);
    apb(1'b1, 12'h01c, dref[255:224]);
    repeat (3) @(posedge pclk);
    chk("late", dl, 1);
    apb(1'b0, 12'h040, 0);
    chk("status", rd, sexp(1, 0));
    apb(1'b1, 12'h048, 32'h3);
    apb(1'b0, 12'h044, 0);
    chk("cleared", rd, 0);
    chk("irq", irq, 0);
    apb(1'b1, 12'h04c, 0);
    wkey(12'h020, tref);
    apb(1'b0, 12'h044, 0);
    chk("event", rd, 2);
    chk("masked", irq, 0);
    apb(1'b1, 12'h04c, 2);
    apb(1'b0, 12'h100, 0);
    chk("irq", irq, 1);
    chk("err", err, 1);
    chk("unmapped", rd, 0);
    @(posedge pclk);
    dref <= '1;
    repeat (4) @(posedge pclk);
    chk("ones", dl, 0);
    final_report;
  end
endmodule : tb
`default_nettype wire
